// ---- logic/sysbus_arb_pins.sv ----
// Summary of operation
// - Generate write parity and check read parity on lane b, data byte D8-15.
// - Generate and check parity on lane c for data byte D16-23.
// - Generate and check parity on lane d for data byte D24-31.
// - Generate and check parity on lane a for data byte D0-7.
// - Parity enable chosen per memory bank, and once for all other slaves.
// - Eight external interrupt request lines are passed to the interrupt controller.
// - Request 4 is lane b pin AND kill-reservation pin, where so configured.
// - Request 5 is lane c pin AND debug serial input, where so configured.
// - Request 6 is lane d pin AND freeze pin, where so configured.
// - Bus request is active low; input while the internal arbiter is used.
// - External arbiter: drive request low for a new transaction when not parked.
// - Internal arbiter: drive grant low when the outside master outranks internal sources.
// - External arbiter: grant is an input, low gives this device the bus.
// - Owner holds busy low; assert only after grant and busy seen negated.
// - Drive freeze while the core is in debug mode.
//
// Added by the designer: the APB interface to the registers and the register offsets.
module sysbus_arb_pins (
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        NRST,
  // APB register port
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             INT_OUT,
  // Internal bus interface side, bit 31 is D0
  input  wire logic        REQ_VALID,
  input  wire logic [2:0]  REQ_PRIO,
  input  wire logic        XFER_WRITE,
  input  wire logic        XFER_DONE,
  input  wire logic        BANK_HIT,
  input  wire logic [2:0]  BANK_SEL,
  input  wire logic [31:0] WR_DATA,
  input  wire logic        RD_STROBE,
  input  wire logic [31:0] RD_DATA,
  output logic             OWNS_BUS,
  // Core side
  input  wire logic        DEBUG_MODE,
  output logic [7:0]       EXT_INT_REQ_N,
  // Arbitration pins
  input  wire logic        BUS_REQUEST_N_I,
  output logic             BUS_REQUEST_N_O,
  output logic             BUS_REQUEST_N_OE,
  input  wire logic        BUS_GRANT_N_I,
  output logic             BUS_GRANT_N_O,
  output logic             BUS_GRANT_N_OE,
  input  wire logic        BUS_BUSY_N_I,
  output logic             BUS_BUSY_N_O,
  output logic             BUS_BUSY_N_OE,
  // Parity lanes, index 0 is lane a
  input  wire logic [3:0]  PARITY_LANE_I,
  output logic      [3:0]  PARITY_LANE_O,
  output logic      [3:0]  PARITY_LANE_OE,
  // Shared and dedicated request pins
  input  wire logic        KILL_RESV_OR_RETRY,
  input  wire logic        DEBUG_SERIAL_IN,
  input  wire logic        DEBUG_FREEZE_I,
  output logic             DEBUG_FREEZE_O,
  output logic             DEBUG_FREEZE_OE,
  input  wire logic        EXT_INT_REQ_0,
  input  wire logic        EXT_INT_REQ_1,
  input  wire logic        EXT_INT_REQ_2,
  input  wire logic        EXT_INT_REQ_3,
  input  wire logic        EXT_INT_REQ_7
);

  // ****************************************************************
  // State and decoded settings
  // ****************************************************************
  sysbus_pins_pkg::pins_state_t s_r;
  sysbus_pins_pkg::pins_state_t s_nxt;

  logic                            ext_arb;
  logic                            odd;
  logic                            par_on;
  logic [sysbus_pins_pkg::PIN_W-1:0] pins_raw;
  logic [3:0]                      perr;
  logic [4:0]                      events;
  logic                            setup;
  logic                            wr_acc;

  assign ext_arb = s_r.ctrl[sysbus_pins_pkg::CT_EXT_ARB];
  assign odd     = s_r.ctrl[sysbus_pins_pkg::CT_ODD];
  assign setup   = PSEL && !PENABLE;
  assign wr_acc  = PSEL && PENABLE && PWRITE;

  // Parity enable for the slave being addressed now
  assign par_on = BANK_HIT ? s_r.par_en[BANK_SEL]
                           : s_r.par_en[sysbus_pins_pkg::PE_OTHER];

  // All pins gathered for the two-stage synchroniser
  assign pins_raw = {EXT_INT_REQ_7, EXT_INT_REQ_3, EXT_INT_REQ_2, EXT_INT_REQ_1,
                     EXT_INT_REQ_0, PARITY_LANE_I, DEBUG_FREEZE_I, DEBUG_SERIAL_IN,
                     KILL_RESV_OR_RETRY, BUS_BUSY_N_I, BUS_GRANT_N_I, BUS_REQUEST_N_I};

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Read data is delayed two cycles so it lines up with the synchronised parity pins
  always_comb begin
    logic br_low;
    logic bg_low;
    logic bb_high;
    logic t_dpa;
    logic t_dpb;
    logic t_dpc;
    logic t_dpd;
    logic t_kr;
    logic t_debug_serial_in;
    logic t_frz;
    br_low  = 1'b0;
    bg_low  = 1'b0;
    bb_high = 1'b0;
    t_dpa   = 1'b1;
    t_dpb   = 1'b1;
    t_dpc   = 1'b1;
    t_dpd   = 1'b1;
    t_kr    = 1'b1;
    t_debug_serial_in  = 1'b1;
    t_frz   = 1'b1;
    s_nxt   = s_r;
    perr    = 4'h0;
    events  = 5'h00;
    br_low  = !s_r.pin_s2[sysbus_pins_pkg::PIN_BR];
    bg_low  = !s_r.pin_s2[sysbus_pins_pkg::PIN_BG];
    bb_high = s_r.pin_s2[sysbus_pins_pkg::PIN_BB];

    // Synchroniser: stage one feeds only stage two
    s_nxt.pin_s1 = pins_raw;
    s_nxt.pin_s2 = s_r.pin_s1;

    // Arbitration
    case (s_r.arb)
      sysbus_pins_pkg::ARB_IDLE: begin
        if (ext_arb) begin
          if (REQ_VALID && s_r.ctrl[sysbus_pins_pkg::CT_PARK] && bg_low) begin
            s_nxt.arb = sysbus_pins_pkg::ARB_WAITBB;
          end else if (REQ_VALID) begin
            s_nxt.arb = sysbus_pins_pkg::ARB_REQ;
          end
        end else if (br_low && (!REQ_VALID || s_r.ext_prio > REQ_PRIO)) begin
          s_nxt.arb = sysbus_pins_pkg::ARB_EXT;
          events[sysbus_pins_pkg::ST_EXT_GNT] = 1'b1;
        end else if (REQ_VALID) begin
          s_nxt.arb = sysbus_pins_pkg::ARB_WAITBB;
        end
      end
      sysbus_pins_pkg::ARB_REQ: begin
        if (!ext_arb || !REQ_VALID) begin
          s_nxt.arb = sysbus_pins_pkg::ARB_IDLE;
        end else if (bg_low) begin
          s_nxt.arb = sysbus_pins_pkg::ARB_WAITBB;
        end
      end
      sysbus_pins_pkg::ARB_WAITBB: begin
        if (bb_high) begin
          s_nxt.arb = sysbus_pins_pkg::ARB_OWN;
        end
      end
      sysbus_pins_pkg::ARB_OWN: begin
        if (XFER_DONE) begin
          s_nxt.arb = sysbus_pins_pkg::ARB_IDLE;
        end
      end
      sysbus_pins_pkg::ARB_EXT: begin
        if (!br_low) begin
          s_nxt.arb = sysbus_pins_pkg::ARB_IDLE;
        end
      end
      default: begin
        s_nxt.arb = sysbus_pins_pkg::ARB_IDLE;
      end
    endcase

    // Parity generation on write data and check of delayed read data
    s_nxt.rd_d1 = RD_DATA;
    s_nxt.rd_d2 = s_r.rd_d1;
    s_nxt.rd_v1 = RD_STROBE && par_on && (s_r.arb == sysbus_pins_pkg::ARB_OWN);
    s_nxt.rd_v2 = s_r.rd_v1;
    for (int i = 0; i < 4; i++) begin
      s_nxt.par_out[i] = (^WR_DATA[31-8*i -: 8]) ^ odd;
      perr[i] = s_r.rd_v2 && !s_r.pin_fn[i] &&
                (s_r.pin_s2[sysbus_pins_pkg::PIN_DP+i] !=
                 ((^s_r.rd_d2[31-8*i -: 8]) ^ odd));
    end
    events[3:0] = perr;

    // Interrupt merge terms, high when a pin is not an interrupt source
    if (s_r.pin_fn[sysbus_pins_pkg::PF_DPA_IRQ]) t_dpa = s_r.pin_s2[sysbus_pins_pkg::PIN_DP];
    if (s_r.pin_fn[sysbus_pins_pkg::PF_DPB_IRQ]) t_dpb = s_r.pin_s2[sysbus_pins_pkg::PIN_DP+1];
    if (s_r.pin_fn[sysbus_pins_pkg::PF_DPC_IRQ]) t_dpc = s_r.pin_s2[sysbus_pins_pkg::PIN_DP+2];
    if (s_r.pin_fn[sysbus_pins_pkg::PF_DPD_IRQ]) t_dpd = s_r.pin_s2[sysbus_pins_pkg::PIN_DP+3];
    if (s_r.pin_fn[sysbus_pins_pkg::PF_KR_IRQ])   t_kr   = s_r.pin_s2[sysbus_pins_pkg::PIN_KR];
    if (s_r.pin_fn[sysbus_pins_pkg::PF_DEBUG_SERIAL_IN_IRQ]) t_debug_serial_in = s_r.pin_s2[sysbus_pins_pkg::PIN_DEBUG_SERIAL_IN];
    if (s_r.pin_fn[sysbus_pins_pkg::PF_FRZ_IRQ])  t_frz  = s_r.pin_s2[sysbus_pins_pkg::PIN_FRZ];
    s_nxt.irq[0] = s_r.pin_s2[sysbus_pins_pkg::PIN_EXT_INT_REQ_0];
    s_nxt.irq[1] = s_r.pin_s2[sysbus_pins_pkg::PIN_EXT_INT_REQ_1];
    s_nxt.irq[2] = s_r.pin_s2[sysbus_pins_pkg::PIN_IRQ2];
    s_nxt.irq[3] = s_r.pin_s2[sysbus_pins_pkg::PIN_IRQ3] & t_dpa;
    s_nxt.irq[4] = t_dpb & t_kr;
    s_nxt.irq[5] = t_dpc & t_debug_serial_in;
    s_nxt.irq[6] = t_dpd & t_frz;
    s_nxt.irq[7] = s_r.pin_s2[sysbus_pins_pkg::PIN_EXT_INT_REQ_7];
    s_nxt.freeze = DEBUG_MODE;

    // Register writes take effect at the access edge
    if (wr_acc && PADDR == sysbus_pins_pkg::OFF_CTRL) begin
      s_nxt.ctrl     = PWDATA[2:0];
      s_nxt.ext_prio = PWDATA[sysbus_pins_pkg::CT_PRIO_LSB +: 3];
    end else if (wr_acc && PADDR == sysbus_pins_pkg::OFF_PAR_EN) begin
      s_nxt.par_en = PWDATA[8:0];
    end else if (wr_acc && PADDR == sysbus_pins_pkg::OFF_PIN_FN) begin
      s_nxt.pin_fn = PWDATA[6:0];
    end else if (wr_acc && PADDR == sysbus_pins_pkg::OFF_INT_EN) begin
      s_nxt.int_en = PWDATA[4:0];
    end

    // Sticky status: a new event wins over a clear in the same cycle
    if (wr_acc && PADDR == sysbus_pins_pkg::OFF_INT_CLR) begin
      s_nxt.int_stat = (s_r.int_stat & ~PWDATA[4:0]) | events;
    end else begin
      s_nxt.int_stat = s_r.int_stat | events;
    end

    // Read data captured in the setup cycle so the access needs no wait
    if (setup) begin
      s_nxt.prdata  = 32'h0000_0000;
      s_nxt.pslverr = 1'b0;
      if (PADDR == sysbus_pins_pkg::OFF_CTRL) begin
        s_nxt.prdata[2:0] = s_r.ctrl;
        s_nxt.prdata[sysbus_pins_pkg::CT_PRIO_LSB +: 3] = s_r.ext_prio;
      end else if (PADDR == sysbus_pins_pkg::OFF_PAR_EN) begin
        s_nxt.prdata[8:0] = s_r.par_en;
      end else if (PADDR == sysbus_pins_pkg::OFF_PIN_FN) begin
        s_nxt.prdata[6:0] = s_r.pin_fn;
      end else if (PADDR == sysbus_pins_pkg::OFF_INT_STAT) begin
        s_nxt.prdata[4:0] = s_r.int_stat;
      end else if (PADDR == sysbus_pins_pkg::OFF_INT_EN) begin
        s_nxt.prdata[4:0] = s_r.int_en;
      end else if (PADDR == sysbus_pins_pkg::OFF_INT_CLR) begin
        s_nxt.prdata = 32'h0000_0000;
      end else if (PADDR == sysbus_pins_pkg::OFF_STATE) begin
        s_nxt.prdata[4:0] = s_r.arb;
        s_nxt.prdata[sysbus_pins_pkg::SV_IRQ_LSB +: 8] = s_r.irq;
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      s_r          <= '0;
      s_r.arb      <= sysbus_pins_pkg::ARB_IDLE;
      s_r.ctrl     <= sysbus_pins_pkg::RST_CTRL;
      s_r.ext_prio <= sysbus_pins_pkg::RST_PRIO;
      s_r.par_en   <= sysbus_pins_pkg::RST_PAR_EN;
      s_r.pin_fn   <= sysbus_pins_pkg::RST_PIN_FN;
      s_r.pin_s1   <= sysbus_pins_pkg::RST_PINS;
      s_r.pin_s2   <= sysbus_pins_pkg::RST_PINS;
      s_r.irq      <= '1;                                     // Request lines idle high
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Pins left undriven rely on board pull-ups to read high
  assign PRDATA           = s_r.prdata;
  assign PREADY           = 1'b1;
  assign PSLVERR          = s_r.pslverr && PSEL && PENABLE;
  assign INT_OUT          = |(s_r.int_stat & s_r.int_en);
  assign OWNS_BUS         = (s_r.arb == sysbus_pins_pkg::ARB_OWN);
  assign EXT_INT_REQ_N    = s_r.irq;
  assign BUS_REQUEST_N_OE = ext_arb;
  assign BUS_REQUEST_N_O  = (s_r.arb != sysbus_pins_pkg::ARB_REQ);
  assign BUS_GRANT_N_OE   = !ext_arb;
  assign BUS_GRANT_N_O    = (s_r.arb != sysbus_pins_pkg::ARB_EXT);
  assign BUS_BUSY_N_OE    = OWNS_BUS;
  assign BUS_BUSY_N_O     = 1'b0;
  assign PARITY_LANE_O    = s_r.par_out;
  assign PARITY_LANE_OE   = {4{OWNS_BUS && XFER_WRITE && par_on}} & ~s_r.pin_fn[3:0];
  assign DEBUG_FREEZE_O   = s_r.freeze;
  assign DEBUG_FREEZE_OE  = !s_r.pin_fn[sysbus_pins_pkg::PF_FRZ_IRQ];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_par_gen_b;
    @(posedge MCLK) disable iff (!NRST)
    PARITY_LANE_OE[1] |-> PARITY_LANE_O[1] == (^($past(WR_DATA) & 32'h00FF_0000) ^ $past(odd));
  endproperty
  a_par_gen_b: assert property (p_par_gen_b) else $error("lane b parity wrong");

  property p_par_gen_c;
    @(posedge MCLK) disable iff (!NRST)
    PARITY_LANE_OE[2] |-> PARITY_LANE_O[2] == (^($past(WR_DATA) & 32'h0000_FF00) ^ $past(odd));
  endproperty
  a_par_gen_c: assert property (p_par_gen_c) else $error("lane c parity wrong");

  property p_par_chk_d;
    @(posedge MCLK) disable iff (!NRST)
    (perr[3] && !(wr_acc && PADDR == sysbus_pins_pkg::OFF_INT_CLR)) |=> s_r.int_stat[3];
  endproperty
  a_par_chk_d: assert property (p_par_chk_d) else $error("lane d error lost");

  property p_par_gen_a;
    @(posedge MCLK) disable iff (!NRST)
    PARITY_LANE_OE[0] |-> PARITY_LANE_O[0] == (^($past(WR_DATA) & 32'hFF00_0000) ^ $past(odd));
  endproperty
  a_par_gen_a: assert property (p_par_gen_a) else $error("lane a parity wrong");

  property p_par_sel;
    @(posedge MCLK) disable iff (!NRST)
    (OWNS_BUS && XFER_WRITE && !BANK_HIT && !s_r.par_en[sysbus_pins_pkg::PE_OTHER])
      |-> PARITY_LANE_OE == 4'h0;
  endproperty
  a_par_sel: assert property (p_par_sel) else $error("parity driven while off");

  property p_ext_int_req_4_merge;
    @(posedge MCLK) disable iff (!NRST)
    (s_r.pin_fn[sysbus_pins_pkg::PF_KR_IRQ] && !s_r.pin_s2[sysbus_pins_pkg::PIN_KR])
      |=> !EXT_INT_REQ_N[4];
  endproperty
  a_ext_int_req_4_merge: assert property (p_ext_int_req_4_merge) else $error("request 4 not merged");

  property p_ext_int_req_6_idle;
    @(posedge MCLK) disable iff (!NRST)
    (!s_r.pin_fn[sysbus_pins_pkg::PF_FRZ_IRQ] && !s_r.pin_fn[sysbus_pins_pkg::PF_DPD_IRQ])
      |=> EXT_INT_REQ_N[6];
  endproperty
  a_ext_int_req_6_idle: assert property (p_ext_int_req_6_idle) else $error("request 6 active unused");

  property p_br_in;
    @(posedge MCLK) disable iff (!NRST)
    !ext_arb |-> !BUS_REQUEST_N_OE && BUS_GRANT_N_OE;
  endproperty
  a_br_in: assert property (p_br_in) else $error("request pin driven");

  property p_br_out;
    @(posedge MCLK) disable iff (!NRST)
    (s_r.arb == sysbus_pins_pkg::ARB_IDLE && ext_arb && REQ_VALID &&
     !s_r.ctrl[sysbus_pins_pkg::CT_PARK]) |=> !BUS_REQUEST_N_O;
  endproperty
  a_br_out: assert property (p_br_out) else $error("request not asserted");

  property p_bg_out;
    @(posedge MCLK) disable iff (!NRST)
    (s_r.arb == sysbus_pins_pkg::ARB_IDLE && !ext_arb && !REQ_VALID &&
     !s_r.pin_s2[sysbus_pins_pkg::PIN_BR]) |=> !BUS_GRANT_N_O;
  endproperty
  a_bg_out: assert property (p_bg_out) else $error("grant not given");

  property p_bb_own;
    @(posedge MCLK) disable iff (!NRST)
    $rose(BUS_BUSY_N_OE) |-> $past(s_r.pin_s2[sysbus_pins_pkg::PIN_BB]);
  endproperty
  a_bb_own: assert property (p_bb_own) else $error("busy taken while busy");

  property p_freeze;
    @(posedge MCLK) disable iff (!NRST)
    DEBUG_MODE |=> DEBUG_FREEZE_O;
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze not asserted");

endmodule : sysbus_arb_pins

// ---- logic/sysbus_pins_pkg.sv ----
package sysbus_pins_pkg;

  // ****************************************************************
  // Register map and widths
  // ****************************************************************
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_PAR_EN   = 12'h004;
  localparam logic [11:0] OFF_PIN_FN   = 12'h008;
  localparam logic [11:0] OFF_INT_STAT = 12'h00C;
  localparam logic [11:0] OFF_INT_EN   = 12'h010;
  localparam logic [11:0] OFF_INT_CLR  = 12'h014;
  localparam logic [11:0] OFF_STATE    = 12'h018;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CT_EXT_ARB  = 0;   // External arbiter selected
  localparam int CT_PARK     = 1;   // Bus parking granted by external arbiter
  localparam int CT_ODD      = 2;   // Odd parity when set
  localparam int CT_PRIO_LSB = 8;   // External master priority, 3 bits
  localparam int PE_OTHER    = 8;   // Parity enable for non-bank slaves
  localparam int PF_DPA_IRQ  = 0;
  localparam int PF_DPB_IRQ  = 1;
  localparam int PF_DPC_IRQ  = 2;
  localparam int PF_DPD_IRQ  = 3;
  localparam int PF_KR_IRQ   = 4;
  localparam int PF_DEBUG_SERIAL_IN_IRQ = 5;
  localparam int PF_FRZ_IRQ  = 6;
  localparam int ST_EXT_GNT  = 4;   // Bits 3:0 are lane parity errors
  localparam int SV_IRQ_LSB  = 8;   // State register: interrupt lines

  // Synchronised pin vector positions
  localparam int PIN_W    = 15;
  localparam int PIN_BR   = 0;
  localparam int PIN_BG   = 1;
  localparam int PIN_BB   = 2;
  localparam int PIN_KR   = 3;
  localparam int PIN_DEBUG_SERIAL_IN = 4;
  localparam int PIN_FRZ  = 5;
  localparam int PIN_DP   = 6;      // Four lanes, 6..9
  localparam int PIN_EXT_INT_REQ_0 = 10;
  localparam int PIN_EXT_INT_REQ_1 = 11;
  localparam int PIN_IRQ2 = 12;
  localparam int PIN_IRQ3 = 13;
  localparam int PIN_EXT_INT_REQ_7 = 14;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [2:0]  RST_CTRL   = 3'h0;
  localparam logic [2:0]  RST_PRIO   = 3'h0;
  localparam logic [8:0]  RST_PAR_EN = 9'h000;
  localparam logic [6:0]  RST_PIN_FN = 7'h00;
  localparam logic [PIN_W-1:0] RST_PINS = 15'h7FFF;  // All lines idle high

  typedef enum logic [4:0] {
    ARB_IDLE   = 5'b00001,
    ARB_REQ    = 5'b00010,
    ARB_WAITBB = 5'b00100,
    ARB_OWN    = 5'b01000,
    ARB_EXT    = 5'b10000
  } arb_state_t;

  // Whole state of the pin block
  typedef struct packed {
    arb_state_t       arb;
    logic [2:0]       ctrl;
    logic [2:0]       ext_prio;
    logic [8:0]       par_en;
    logic [6:0]       pin_fn;
    logic [4:0]       int_stat;
    logic [4:0]       int_en;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [31:0]      rd_d1;
    logic [31:0]      rd_d2;
    logic             rd_v1;
    logic             rd_v2;
    logic [3:0]       par_out;
    logic [7:0]       irq;
    logic             freeze;
    logic [31:0]      prdata;
    logic             pslverr;
  } pins_state_t;

endpackage : sysbus_pins_pkg

// ---- verification/ext_bus_model.sv ----
module ext_bus_model (
  // Clock
  input  wire logic       clk,
  // Device side of the shared pins
  input  wire logic       br_o,
  input  wire logic       br_oe,
  input  wire logic       bg_o,
  input  wire logic       bg_oe,
  input  wire logic       bb_o,
  input  wire logic       bb_oe,
  input  wire logic [3:0] par_o,
  input  wire logic [3:0] par_oe,
  // Far side behaviour, steered by the bench
  input  wire logic       want,
  input  wire logic       hold,
  input  wire logic [3:0] spar,
  // Resolved wire levels
  output logic            br_w,
  output logic            bg_w,
  output logic            bb_w,
  output logic      [3:0] par_w
);
  timeunit 1ns;
  timeprecision 1ns;
  logic gnt_n = 1'h1;
  // Outside master pulls request low, pull-up otherwise
  assign br_w = br_oe ? br_o : !want;
  // Grant kept until the device shows busy, so a slow previous owner cannot lose it
  always @(posedge clk) begin
    if (!br_w) gnt_n <= 1'h0;
    else if (bb_oe && !bb_o) gnt_n <= 1'h1;
  end
  assign bg_w = bg_oe ? bg_o : gnt_n;
  // Previous owner or granted outside master holds busy low
  assign bb_w = bb_oe ? bb_o : !(hold || (want && !bg_w));
  assign par_w = (par_oe & par_o) | (~par_oe & spar);
endmodule : ext_bus_model

// ---- verification/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Signals
  // ****
  logic        mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, wr_data = '0, rd_data = '0, q;
  logic        req_valid = 0, xfer_write = 0, xfer_done = 0, bank_hit = 0, rd_strobe = 0;
  logic        dbg = 0, kr = 1, debug_serial_in = 1, debug_freeze = 1, want = 0, hold = 0, owns, int_out;
  logic [2:0]  req_prio = '0, bank_sel = '0, wv;
  logic [4:0]  ir = '1;
  logic [3:0]  spar = '1, par_w, par_o, par_oe;
  logic [7:0]  irq_n;
  logic        br_w, bg_w, bb_w, br_o, br_oe, bg_o, bg_oe, bb_o, bb_oe, fo, foe, frz_w;
  int          num_errors = 0, comparisons = 0;
  always #25 mclk = ~mclk;
  // Freeze pin level: device drives or bench drives
  assign frz_w = foe ? fo : debug_freeze;
  // Watched single-bit outputs: 0 owns, 1 request, 2 grant
  assign wv = {bg_o, br_o, owns};
  sysbus_arb_pins sysbus_arb_pins_inst (
    .MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .INT_OUT(int_out), .REQ_VALID(req_valid), .REQ_PRIO(req_prio), .XFER_WRITE(xfer_write),
    .XFER_DONE(xfer_done), .BANK_HIT(bank_hit), .BANK_SEL(bank_sel), .WR_DATA(wr_data),
    .RD_STROBE(rd_strobe), .RD_DATA(rd_data), .OWNS_BUS(owns), .DEBUG_MODE(dbg),
    .EXT_INT_REQ_N(irq_n), .BUS_REQUEST_N_I(br_w), .BUS_REQUEST_N_O(br_o),
    .BUS_REQUEST_N_OE(br_oe), .BUS_GRANT_N_I(bg_w), .BUS_GRANT_N_O(bg_o),
    .BUS_GRANT_N_OE(bg_oe), .BUS_BUSY_N_I(bb_w), .BUS_BUSY_N_O(bb_o), .BUS_BUSY_N_OE(bb_oe),
    .PARITY_LANE_I(par_w), .PARITY_LANE_O(par_o), .PARITY_LANE_OE(par_oe),
    .KILL_RESV_OR_RETRY(kr), .DEBUG_SERIAL_IN(debug_serial_in), .DEBUG_FREEZE_I(frz_w),
    .DEBUG_FREEZE_O(fo), .DEBUG_FREEZE_OE(foe), .EXT_INT_REQ_0(ir[0]),
    .EXT_INT_REQ_1(ir[1]), .EXT_INT_REQ_2(ir[2]), .EXT_INT_REQ_3(ir[3]), .EXT_INT_REQ_7(ir[4]));
  ext_bus_model ext_bus_model_inst (
    .clk(mclk), .br_o(br_o), .br_oe(br_oe), .bg_o(bg_o), .bg_oe(bg_oe), .bb_o(bb_o),
    .bb_oe(bb_oe), .par_o(par_o), .par_oe(par_oe), .want(want), .hold(hold), .spar(spar),
    .br_w(br_w), .bg_w(bg_w), .bb_w(bb_w), .par_w(par_w));
  // ****
  // Shared tasks
  // ****
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task print_verdict;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict
  // One APB transfer, held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    for (int n = 0; n < 50; n++) begin
      @(posedge mclk);
      if (pready === 1'h1) break;
    end
    if (pready !== 1'h1) begin
      num_errors++;
      print_verdict;
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    // One idle cycle, so a following call never reassigns psel in this time step
    @(posedge mclk);
  endtask : apb
  // Bounded wait for a watched output
  task wt(input int i, input logic v);
    for (int n = 0; n < 300 && wv[i] !== v; n++) @(posedge mclk);
    if (wv[i] !== v) begin
      num_errors++;
      print_verdict;
    end
  endtask : wt
  task end_xfer;
    xfer_done <= 1'h1;
    @(posedge mclk);
    xfer_done <= 1'h0;
    wt(0, 1'h0);
  endtask : end_xfer
  // ****
  // Scenarios
  // ****
  task regs_reset;
    chk("irq_n", irq_n, 8'hFF);
    apb(0, sysbus_pins_pkg::OFF_CTRL, '0);
    chk("ctrl", q, 32'h0);
    apb(1, 12'hFFC, 32'hFFFF_FFFF);
    chk("slverr", err, 1'h1);
  endtask : regs_reset
  // Pin patterns under both pin functions; last pass leaves pins as parity
  task irq_merge;
    logic [11:0] p [4];
    logic [6:0]  fn;
    logic [7:0]  e;
    p = '{12'hFFF, 12'h000, 12'hA5A, 12'h5A5};
    for (int f = 0; f < 2; f++) begin
      fn = f ? 7'h00 : 7'h7F;
      apb(1, sysbus_pins_pkg::OFF_PIN_FN, {25'h0, fn});
      for (int k = 0; k < 4; k++) begin
        {debug_freeze, debug_serial_in, kr, spar, ir} <= p[k];
        repeat (4) @(posedge mclk);
        e = {ir[4], (spar[3] | ~fn[3]) & (debug_freeze | ~fn[6]), (spar[2] | ~fn[2]) & (debug_serial_in | ~fn[5]),
             (spar[1] | ~fn[1]) & (kr | ~fn[4]), ir[3] & (spar[0] | ~fn[0]), ir[2:0]};
        chk("irq_n", irq_n, e);
      end
    end
    {debug_freeze, debug_serial_in, kr, spar, ir} <= '1;
  endtask : irq_merge
  // External arbiter, slow previous owner, parity out and parity error in
  task ext_arb;
    apb(1, sysbus_pins_pkg::OFF_CTRL, 32'h1);
    apb(1, sysbus_pins_pkg::OFF_PAR_EN, 32'h100);
    apb(1, sysbus_pins_pkg::OFF_INT_EN, 32'h2);
    hold <= 1'h1;
    xfer_write <= 1'h1;
    wr_data <= 32'h0103_07FF;
    req_valid <= 1'h1;
    wt(1, 1'h0);
    chk("br_oe", br_oe, 1'h1);
    repeat (8) @(posedge mclk);
    chk("owns", owns, 1'h0);
    hold <= 1'h0;
    wt(0, 1'h1);
    chk("busy", {bb_o, bb_oe}, 2'h1);
    req_valid <= 1'h0;
    repeat (2) @(posedge mclk);
    chk("par", {par_oe, par_o}, 8'hF5);
    // Odd parity inverts every lane
    apb(1, sysbus_pins_pkg::OFF_CTRL, 32'h5);
    @(posedge mclk);
    chk("par_odd", par_o, 4'hA);
    apb(1, sysbus_pins_pkg::OFF_CTRL, 32'h1);
    bank_hit <= 1'h1;
    bank_sel <= 3'h2;
    repeat (2) @(posedge mclk);
    chk("par_oe", par_oe, 4'h0);
    apb(1, sysbus_pins_pkg::OFF_PAR_EN, 32'h4);
    @(posedge mclk);
    chk("par_oe", par_oe, 4'hF);
    // Lanes b and d answer with the wrong parity
    xfer_write <= 1'h0;
    rd_data <= 32'h0103_07FF;
    spar <= 4'hF;
    rd_strobe <= 1'h1;
    @(posedge mclk);
    rd_strobe <= 1'h0;
    repeat (5) @(posedge mclk);
    apb(0, sysbus_pins_pkg::OFF_INT_STAT, '0);
    chk("stat", q, 32'hA);
    chk("int", int_out, 1'h1);
    apb(1, sysbus_pins_pkg::OFF_INT_CLR, 32'h1F);
    @(posedge mclk);
    chk("int", int_out, 1'h0);
    spar <= '1;
    bank_hit <= 1'h0;
    end_xfer;
    chk("bb_oe", bb_oe, 1'h0);
  endtask : ext_arb
  // Internal arbiter: outside master wins at low, loses at high internal priority
  task int_arb;
    apb(1, sysbus_pins_pkg::OFF_CTRL, 32'h300);
    req_prio <= 3'h2;
    // The internal request must meet the synchronised outside request at one edge
    want <= 1'h1;
    repeat (2) @(posedge mclk);
    req_valid <= 1'h1;
    wt(2, 1'h0);
    chk("bg_oe", bg_oe, 1'h1);
    apb(0, sysbus_pins_pkg::OFF_INT_STAT, '0);
    chk("stat", q, 32'h10);
    want <= 1'h0;
    req_valid <= 1'h0;
    wt(2, 1'h1);
    req_prio <= 3'h4;
    want <= 1'h1;
    repeat (2) @(posedge mclk);
    req_valid <= 1'h1;
    wt(0, 1'h1);
    chk("bg", bg_o, 1'h1);
    want <= 1'h0;
    req_valid <= 1'h0;
    end_xfer;
  endtask : int_arb
  task freeze_chk;
    dbg <= 1'h1;
    repeat (3) @(posedge mclk);
    chk("frz", {fo, foe}, 2'h3);
    dbg <= 1'h0;
    repeat (3) @(posedge mclk);
    chk("frz", fo, 1'h0);
  endtask : freeze_chk
  // ****
  // Main sequence
  // ****
  initial begin
    repeat (12) @(posedge mclk);
    nrst <= 1'h1;
    @(posedge mclk);
    regs_reset;
    irq_merge;
    ext_arb;
    int_arb;
    freeze_chk;
    print_verdict;
  end
endmodule : tb_top
